// *** src/oob_mgmt_params.svh ***
`ifndef OOB_MGMT_PARAMS_SVH
`define OOB_MGMT_PARAMS_SVH

// system clock, 125 MHz
`define OOB_CLK_HZ 32'h0773_5940
// line rates in baud: 2400, 9600, 19200, 38400
`define OOB_BAUD_2400 32'h0000_0960
`define OOB_BAUD_9600 32'h0000_2580
`define OOB_BAUD_19200 32'h0000_4B00
`define OOB_BAUD_38400 32'h0000_9600
// rate selector codes
`define OOB_SEL_2400 2'h0
`define OOB_SEL_9600 2'h1
`define OOB_SEL_19200 2'h2
`define OOB_SEL_38400 2'h3
// reset values of the configuration
`define OOB_RATE_RESET `OOB_SEL_9600
`define OOB_GATE_RESET 1'h0
// samples per bit time
`define OOB_OVERSAMPLE 32'h0000_0010

`endif

// *** src/oob_mgmt_pkg.sv ***
package oob_mgmt_pkg;
   typedef logic [1:0] rate_sel_type;
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
endpackage : oob_mgmt_pkg

// *** src/oob_baud_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface oob_baud_if;
   import oob_mgmt_pkg::*;
   rate_sel_type rate;
   logic enable;
   logic tick;
   modport gen (input rate, input enable, output tick);
   modport user (output rate, output enable, input tick);
endinterface : oob_baud_if
`default_nettype wire

// *** src/oob_baud_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "oob_mgmt_params.svh"
module oob_baud_gen #(
   parameter int OVERSAMPLE = `OOB_OVERSAMPLE
) (
   input wire logic clk,
   input wire logic srst,
   oob_baud_if.gen baud
);
   import oob_mgmt_pkg::*;

   // refuse settings the divider cannot serve at the fastest rate
   if (OVERSAMPLE < 4 || OVERSAMPLE > 64)
   begin : g_check
      $error("oversample must lie between 4 and 64");
   end

   // divide ratio for a rate code, rounded to nearest cycle
   function automatic logic [15:0] divisor(input rate_sel_type sel);
      logic [31:0] bd;
      logic [31:0] den;
      bd = `OOB_BAUD_9600;
      case (sel)
         `OOB_SEL_2400: bd = `OOB_BAUD_2400;
         `OOB_SEL_19200: bd = `OOB_BAUD_19200;
         `OOB_SEL_38400: bd = `OOB_BAUD_38400;
         default: bd = `OOB_BAUD_9600;
      endcase
      den = bd * 32'(OVERSAMPLE);
      return 16'((`OOB_CLK_HZ + (den >> 1)) / den);
   endfunction : divisor

   logic [15:0] cnt;
   logic [15:0] last;

   assign last = divisor(baud.rate) - 16'h0001;

   // free-running divider; held at zero while the port is inactive (undocked or self-test not done)
   always_ff @(posedge clk)
   begin
      if (srst || !baud.enable)
      begin
         cnt <= 16'h0000;
         baud.tick <= 1'b0;
      end
      else if (cnt >= last)
      begin
         // >= so a rate change mid-count cannot overrun the wrap
         cnt <= 16'h0000;
         baud.tick <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 16'h0001;
         baud.tick <= 1'b0;
      end
   end
endmodule : oob_baud_gen
`default_nettype wire

// *** src/oob_mgmt_serial_port.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "oob_mgmt_params.svh"
module oob_mgmt_serial_port #(
   parameter int OVERSAMPLE = `OOB_OVERSAMPLE
) (
   input wire logic SYS_CLK_IN,
   input wire logic SRST_IN,
   input wire logic SINGLE_SLOT_DOCK_IN,
   input wire logic SELF_TEST_DONE_IN,
   input wire logic CFG_LOAD_IN,
   input wire oob_mgmt_pkg::rate_sel_type RATE_SEL_IN,
   input wire logic RATE_STORED_IN,
   input wire logic RTS_GATE_EN_IN,
   input wire logic [7:0] TX_DATA_IN,
   input wire logic TX_VALID_IN,
   output logic TX_READY_OUT,
   input wire logic RXD_IN,
   output logic [7:0] RX_DATA_OUT,
   output logic RX_VALID_OUT,
   output logic RX_FRAME_ERR_OUT,
   output logic TXD_OUT,
   output logic RTS_OUT,
   output oob_mgmt_pkg::rate_sel_type RATE_OUT,
   output logic RTS_GATE_OUT
);
   import oob_mgmt_pkg::*;

   localparam int SW = $clog2(OVERSAMPLE);
   localparam logic [SW-1:0] TICK_LAST = SW'(OVERSAMPLE - 1);
   localparam logic [SW-1:0] TICK_HALF = SW'(OVERSAMPLE / 2 - 1);

   // tick counters wrap by overflow, so any other ratio would stretch every bit after the first one timed from a counter clear
   if (OVERSAMPLE != (1 << SW))
   begin : g_pow2
      $error("oversample must be a power of two");
   end

   oob_baud_if baud ();

   oob_baud_gen #(
      .OVERSAMPLE(OVERSAMPLE)
   ) u_baud (
      .clk(SYS_CLK_IN),
      .srst(SRST_IN),
      .baud(baud)
   );

   logic dock_meta;
   logic dock;
   logic rxd_meta;
   logic rxd;
   logic active;
   logic st_done;
   rate_sel_type rate;
   logic gate_en;

   // two-stage synchronisers for the dock strap and the receive pin
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (SRST_IN)
      begin
         dock_meta <= 1'b0;
         dock <= 1'b0;
         rxd_meta <= 1'b1;
         rxd <= 1'b1;
      end
      else
      begin
         dock_meta <= SINGLE_SLOT_DOCK_IN;
         dock <= dock_meta;
         rxd_meta <= RXD_IN;
         rxd <= rxd_meta;
      end
   end

   // self-test completion is sticky until reset
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (SRST_IN)
         st_done <= 1'b0;
      else if (SELF_TEST_DONE_IN)
         st_done <= 1'b1;
   end

   assign active = dock && st_done;

   // configuration; loads ignored outside the single-slot dock
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (SRST_IN)
      begin
         rate <= `OOB_RATE_RESET;
         gate_en <= `OOB_GATE_RESET;
      end
      else if (CFG_LOAD_IN && dock)
      begin
         rate <= RATE_STORED_IN ? RATE_SEL_IN : `OOB_RATE_RESET;
         gate_en <= RTS_GATE_EN_IN;
      end
   end

   assign baud.rate = rate;
   assign baud.enable = active;
   assign RATE_OUT = rate;
   assign RTS_GATE_OUT = gate_en;

   // transmitter
   tx_state_type tx_state;
   logic [7:0] tx_shift;
   logic [SW-1:0] tx_tick;
   logic [2:0] tx_bit;
   logic tx_take;

   assign TX_READY_OUT = active && (tx_state == TX_IDLE);
   assign tx_take = TX_VALID_IN && TX_READY_OUT;

   // one bit time is OVERSAMPLE ticks; the line goes idle if undocked
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (SRST_IN || !active)
      begin
         tx_state <= TX_IDLE;
         tx_shift <= 8'h00;
         tx_tick <= '0;
         tx_bit <= 3'h0;
         TXD_OUT <= 1'b1;
      end
      else
      begin
         case (tx_state)
            TX_IDLE:
            begin
               TXD_OUT <= 1'b1;
               if (tx_take)
               begin
                  tx_shift <= TX_DATA_IN;
                  tx_tick <= '0;
                  tx_state <= TX_START;
               end
            end
            TX_START:
            begin
               TXD_OUT <= 1'b0;
               if (baud.tick)
               begin
                  tx_tick <= tx_tick + 1'b1;
                  if (tx_tick == TICK_LAST)
                  begin
                     tx_bit <= 3'h0;
                     tx_state <= TX_DATA;
                  end
               end
            end
            TX_DATA:
            begin
               TXD_OUT <= tx_shift[0]; // least significant bit first
               if (baud.tick)
               begin
                  tx_tick <= tx_tick + 1'b1;
                  if (tx_tick == TICK_LAST)
                  begin
                     tx_shift <= {1'b0, tx_shift[7:1]};
                     tx_bit <= tx_bit + 3'h1;
                     if (tx_bit == 3'h7)
                        tx_state <= TX_STOP;
                  end
               end
            end
            TX_STOP:
            begin
               TXD_OUT <= 1'b1;
               if (baud.tick)
               begin
                  tx_tick <= tx_tick + 1'b1;
                  if (tx_tick == TICK_LAST)
                     tx_state <= TX_IDLE; // full stop bit on the wire
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // request-to-send; registered, so it follows its cause by one cycle
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (SRST_IN || !active)
         RTS_OUT <= 1'b0;
      else if (!gate_en)
         RTS_OUT <= 1'b1;
      else
         // pending word or character still in flight, stop bit included
         RTS_OUT <= TX_VALID_IN || (tx_state != TX_IDLE);
   end

   // receiver
   rx_state_type rx_state;
   logic [7:0] rx_shift;
   logic [SW-1:0] rx_tick;
   logic [2:0] rx_bit;

   // start edge checked at mid-bit so glitches shorter than half a bit drop
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (SRST_IN || !active)
      begin
         rx_state <= RX_IDLE;
         rx_shift <= 8'h00;
         rx_tick <= '0;
         rx_bit <= 3'h0;
         RX_DATA_OUT <= 8'h00;
         RX_VALID_OUT <= 1'b0;
         RX_FRAME_ERR_OUT <= 1'b0;
      end
      else
      begin
         RX_VALID_OUT <= 1'b0;
         RX_FRAME_ERR_OUT <= 1'b0;
         case (rx_state)
            RX_IDLE:
            begin
               rx_tick <= '0;
               if (!rxd)
                  rx_state <= RX_START;
            end
            RX_START:
            begin
               if (baud.tick)
               begin
                  rx_tick <= rx_tick + 1'b1;
                  if (rx_tick == TICK_HALF)
                  begin
                     rx_tick <= '0;
                     rx_bit <= 3'h0;
                     rx_state <= rxd ? RX_IDLE : RX_DATA;
                  end
               end
            end
            RX_DATA:
            begin
               if (baud.tick)
               begin
                  rx_tick <= rx_tick + 1'b1;
                  if (rx_tick == TICK_LAST)
                  begin
                     rx_shift <= {rxd, rx_shift[7:1]};
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == 3'h7)
                        rx_state <= RX_STOP;
                  end
               end
            end
            RX_STOP:
            begin
               if (baud.tick)
               begin
                  rx_tick <= rx_tick + 1'b1;
                  if (rx_tick == TICK_LAST)
                  begin
                     // a low stop bit means a rate mismatch or a break
                     RX_DATA_OUT <= rx_shift;
                     RX_VALID_OUT <= rxd;
                     RX_FRAME_ERR_OUT <= !rxd;
                     rx_state <= RX_IDLE;
                  end
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end
endmodule : oob_mgmt_serial_port
`default_nettype wire

// *** tb/oob_mgmt_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module oob_mgmt_props #(
   parameter int OVERSAMPLE = 16
) (
   input wire logic SYS_CLK_IN,
   input wire logic SRST_IN,
   input wire logic SINGLE_SLOT_DOCK_IN,
   input wire logic SELF_TEST_DONE_IN,
   input wire logic CFG_LOAD_IN,
   input wire oob_mgmt_pkg::rate_sel_type RATE_SEL_IN,
   input wire logic RATE_STORED_IN,
   input wire logic RTS_GATE_EN_IN,
   input wire logic TX_VALID_IN,
   input wire logic TX_READY_OUT,
   input wire logic RX_VALID_OUT,
   input wire logic TXD_OUT,
   input wire logic RTS_OUT,
   input wire oob_mgmt_pkg::rate_sel_type RATE_OUT,
   input wire logic RTS_GATE_OUT
);
   import oob_mgmt_pkg::*;
   logic st;
   logic [2:0] dk;
   logic act;
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (SRST_IN);
   // sticky self-test seen
   always_ff @(posedge SYS_CLK_IN)
      if (SRST_IN) st <= 1'h0;
      else if (SELF_TEST_DONE_IN) st <= 1'h1;
   // dock run length, margin over the synchroniser
   always_ff @(posedge SYS_CLK_IN)
      if (SRST_IN || !SINGLE_SLOT_DOCK_IN) dk <= 3'h0;
      else if (dk != 3'h4) dk <= dk + 3'h1;
   assign act = st && dk == 3'h4;
   a_tx_start: assert property (TX_VALID_IN && TX_READY_OUT |=>
      !TX_READY_OUT ##1 !TXD_OUT) else $error("start bit late");
   a_idle_high: assert property (TX_READY_OUT |-> TXD_OUT)
      else $error("line low while idle");
   a_rate_load: assert property (CFG_LOAD_IN && dk == 3'h4 && RATE_STORED_IN |=>
      RATE_OUT == $past(RATE_SEL_IN)) else $error("rate not loaded");
   a_rate_dflt: assert property (CFG_LOAD_IN && dk == 3'h4 && !RATE_STORED_IN |=>
      RATE_OUT == 2'h1 && RTS_GATE_OUT == $past(RTS_GATE_EN_IN)) else $error("bad default");
   a_cfg_undock: assert property (!SINGLE_SLOT_DOCK_IN [*4] ##0 CFG_LOAD_IN |=>
      $stable(RATE_OUT) && $stable(RTS_GATE_OUT)) else $error("load while undocked");
   a_rts_on: assert property (!RTS_GATE_OUT && act |=> RTS_OUT)
      else $error("rts not held");
   a_rts_gated: assert property (RTS_GATE_OUT && act && TX_VALID_IN |=> RTS_OUT)
      else $error("rts not raised");
   a_rts_drop: assert property (RTS_GATE_OUT && !TX_VALID_IN && TX_READY_OUT |=>
      !RTS_OUT) else $error("rts not dropped");
   c_tx: cover property (TX_VALID_IN && TX_READY_OUT);
   c_rx: cover property (RX_VALID_OUT);
   c_gated: cover property (RTS_GATE_OUT && $rose(RTS_OUT));
endmodule : oob_mgmt_props
bind oob_mgmt_serial_port oob_mgmt_props #(.OVERSAMPLE(OVERSAMPLE)) u_props (
   .SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN), .SINGLE_SLOT_DOCK_IN(SINGLE_SLOT_DOCK_IN),
   .SELF_TEST_DONE_IN(SELF_TEST_DONE_IN), .CFG_LOAD_IN(CFG_LOAD_IN),
   .RATE_SEL_IN(RATE_SEL_IN), .RATE_STORED_IN(RATE_STORED_IN),
   .RTS_GATE_EN_IN(RTS_GATE_EN_IN), .TX_VALID_IN(TX_VALID_IN), .TX_READY_OUT(TX_READY_OUT),
   .RX_VALID_OUT(RX_VALID_OUT), .TXD_OUT(TXD_OUT), .RTS_OUT(RTS_OUT), .RATE_OUT(RATE_OUT),
   .RTS_GATE_OUT(RTS_GATE_OUT));
`default_nettype wire

// *** tb/oob_term_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module oob_term_model #(
   parameter int BIT = 3248
) (
   input wire logic clk_in,
   input wire logic txd_in,
   input wire logic send_in,
   input wire logic [7:0] data_in,
   input wire logic stop_in,
   output logic rxd_out,
   output logic [7:0] got_out
);
   initial rxd_out = 1'h1;
   // capture a frame, sampling mid-bit to ride out start jitter
   always @(negedge txd_in)
   begin : cap
      repeat (BIT / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT) @(posedge clk_in);
         got_out[i] = txd_in;
      end
   end
   // send one 8N1 frame, lsb first, at the agreed rate
   always @(posedge clk_in)
   begin : snd
      if (send_in)
      begin
         for (int i = 0; i < 10; i++)
         begin
            rxd_out <= (i == 0) ? 1'h0 : (i == 9) ? stop_in : data_in[i - 1];
            repeat (BIT) @(posedge clk_in);
         end
         // line back to idle even after a deliberately low stop bit
         rxd_out <= 1'h1;
      end
   end
endmodule : oob_term_model
`default_nettype wire

// *** tb/oob_mgmt_serial_port_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module oob_mgmt_serial_port_tb;
   import oob_mgmt_pkg::*;
   logic clk, srst, dock, st, load, stored, gen, tx_v, rxd, send, ready, rx_v, rx_e, txd, rts;
   logic gate, stop;
   logic [7:0] tx_d, rx_d, got, rx_last, term_d;
   rate_sel_type rsel, rate;
   int n_fail, check_count, cyc, rx_n, rx_err_n;
   oob_mgmt_serial_port dut (.SYS_CLK_IN(clk), .SRST_IN(srst), .SINGLE_SLOT_DOCK_IN(dock),
      .SELF_TEST_DONE_IN(st), .CFG_LOAD_IN(load), .RATE_SEL_IN(rsel), .RATE_STORED_IN(stored),
      .RTS_GATE_EN_IN(gen), .TX_DATA_IN(tx_d), .TX_VALID_IN(tx_v), .TX_READY_OUT(ready),
      .RXD_IN(rxd), .RX_DATA_OUT(rx_d), .RX_VALID_OUT(rx_v), .RX_FRAME_ERR_OUT(rx_e),
      .TXD_OUT(txd), .RTS_OUT(rts), .RATE_OUT(rate), .RTS_GATE_OUT(gate));
   oob_term_model term (.clk_in(clk), .txd_in(txd), .send_in(send), .data_in(term_d),
      .stop_in(stop), .rxd_out(rxd), .got_out(got));
   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // cycle limit and received-byte log, sampled off the launching edge
   always @(negedge clk)
   begin
      cyc++;
      if (rx_v === 1'h1) rx_n++;
      if (rx_v === 1'h1) rx_last = rx_d;
      if (rx_e === 1'h1) rx_err_n++;
      // two frames at the fastest rate take about 65000 cycles
      if (cyc == 80000) n_fail++;
      if (cyc == 80000) finish_test();
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      if (n_fail == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic cfg(input rate_sel_type r, input logic s, input logic g);
      @(posedge clk);
      load <= 1'h1;
      rsel <= r;
      stored <= s;
      gen <= g;
      @(posedge clk);
      load <= 1'h0;
      @(posedge clk);
      #1;
   endtask : cfg
   task automatic t_reset;
      #1;
      check("rate", 8'(rate), 8'h01);
      check("gate", 8'(gate), 8'h00);
      check("txd", 8'(txd), 8'h01);
      @(posedge clk);
      dock <= 1'h1;
      repeat (5) @(posedge clk);
      #1;
      check("rts", 8'(rts), 8'h00);
   endtask : t_reset
   task automatic t_gate_off;
      @(posedge clk);
      st <= 1'h1;
      repeat (3) @(posedge clk);
      #1;
      check("rts", 8'(rts), 8'h01);
      check("ready", 8'(ready), 8'h01);
   endtask : t_gate_off
   task automatic t_rates;
      for (int i = 0; i < 4; i++)
      begin
         cfg(rate_sel_type'(i), 1'h1, 1'h0);
         check("rate", 8'(rate), 8'(i));
      end
      cfg(2'h3, 1'h0, 1'h0);
      check("rate", 8'(rate), 8'h01);
      check("rts", 8'(rts), 8'h01);
   endtask : t_rates
   task automatic t_xfer;
      cfg(2'h3, 1'h1, 1'h1);
      check("gate", 8'(gate), 8'h01);
      check("rts", 8'(rts), 8'h00);
      @(posedge clk);
      tx_d <= 8'hA5;
      tx_v <= 1'h1;
      send <= 1'h1;
      @(posedge clk);
      tx_v <= 1'h0;
      send <= 1'h0;
      #1;
      check("rts", 8'(rts), 8'h01);
      do
      begin
         @(posedge clk);
         #1;
      end while (ready !== 1'h1);
      check("rts", 8'(rts), 8'h01);
      @(posedge clk);
      #1;
      check("rts", 8'(rts), 8'h00);
      check("term", got, 8'hA5);
      check("rx", rx_last, 8'h3C);
      check("rx count", 8'(rx_n), 8'h01);
      check("rx err count", 8'(rx_err_n), 8'h00);
   endtask : t_xfer
   task automatic t_frame_err;
      // let the far end finish the stop bit of its previous frame
      repeat (300) @(posedge clk);
      term_d <= 8'h96;
      stop <= 1'h0;
      send <= 1'h1;
      @(posedge clk);
      send <= 1'h0;
      do
      begin
         @(posedge clk);
         #1;
      end while (rx_err_n == 0);
      check("rx err count", 8'(rx_err_n), 8'h01);
      check("rx count", 8'(rx_n), 8'h01);
      check("rx data", rx_d, 8'h96);
      check("rts", 8'(rts), 8'h00);
   endtask : t_frame_err
   task automatic t_inactive;
      @(posedge clk);
      dock <= 1'h0;
      repeat (5) @(posedge clk);
      cfg(2'h0, 1'h1, 1'h0);
      check("rate", 8'(rate), 8'h03);
      check("gate", 8'(gate), 8'h01);
      check("rts", 8'(rts), 8'h00);
      check("ready", 8'(ready), 8'h00);
   endtask : t_inactive
   initial
   begin
      srst = 1'h1;
      dock = 1'h0;
      st = 1'h0;
      load = 1'h0;
      rsel = 2'h0;
      stored = 1'h0;
      gen = 1'h0;
      tx_v = 1'h0;
      send = 1'h0;
      stop = 1'h1;
      term_d = 8'h3C;
      tx_d = 8'h00;
      repeat (5) @(posedge clk);
      srst <= 1'h0;
      t_reset();
      t_gate_off();
      t_rates();
      t_xfer();
      t_frame_err();
      t_inactive();
      finish_test();
   end
endmodule : oob_mgmt_serial_port_tb
`default_nettype wire
